/* File: apmc_pin_mode_ctl.v */
`timescale 1ns/1ps
`include "apmc_regs.vh"
module apmc_pin_mode_ctl (
   input wire CLK_IN, // master clock, 40 MHz
   input wire RST_IN, // power-on reset, async, active high
   input wire MASTER_RESET_N_IN, // reset pin / oversample_strap_lo pin
   input wire CONV_READY_PIN_IN, // ready pin level / amp_strap_hi
   input wire CRYSTAL_PIN_A_IN, // crystal_pin_a level / amp_strap_lo
   input wire CRYSTAL_PIN_B_IN, // crystal_pin_b / interface mode select
   input wire CHIP_SEL_N_IN, // chip select pin / bias boost strap
   input wire SERIAL_DATA_PIN_IN, // serial data pin / oversample_strap_hi
   input wire WATCHDOG_RESET_IN, // watchdog reset pulse, same clock
   input wire MOD_BIT_IN, // modulator bit from converter
   input wire [1:0] PRESCALE_IN, // analog clock prescaler code
   input wire [2:0] OVERSAMPLING_RATIO_IN, // ratio code, 32 << code
   input wire BITSTREAM_OUT_ENABLE_IN, // modulator output enable
   input wire READY_PIN_TRISTATE_CTL_IN, // 1: ready idles high
   input wire EXTERNAL_CLOCK_SELECT_IN, // 1: direct clock input
   input wire EXTERNAL_REFERENCE_SELECT_IN, // 1: external reference
   output reg CONV_READY_N_OUT, // ready pin output level
   output reg CONV_READY_N_OE_OUT, // ready pin output enable
   output reg MODULATOR_BITSTREAM_OUT, // bitstream pin level
   output reg MODULATOR_BITSTREAM_OE_OUT, // bitstream pin enable
   output reg TWO_WIRE_MODE_OUT, // 1: two-wire interface active
   output reg OVERSAMPLE_STRAP_LO_OUT, // captured strap
   output reg OVERSAMPLE_STRAP_HI_OUT, // captured strap
   output reg AMP_STRAP_LO_OUT, // captured strap
   output reg AMP_STRAP_HI_OUT, // captured strap
   output reg BIAS_BOOST_STRAP_OUT, // captured strap
   output reg CHIP_RESET_OUT, // chip held in reset
   output reg CLOCK_DIST_EN_OUT, // internal clock distribution on
   output reg INPUT_CLOCK_EN_OUT, // input structure clock on
   output reg ANALOG_BIAS_EN_OUT, // analog biasing on
   output reg CRYSTAL_OSC_EN_OUT, // crystal oscillator on
   output reg DIRECT_CLOCK_INPUT_OUT, // crystal pin a used as clock
   output reg INT_REF_EN_OUT, // internal reference on
   output reg REF_PIN_SWITCH_OUT, // internal reference to pin
   output reg ANALOG_MASTER_CLOCK_OUT, // analog clock tick
   output reg DIGITAL_SAMPLE_CLOCK_OUT, // sample clock tick
   output reg OUTPUT_RATE_CLOCK_OUT, // output rate tick
   output reg SERIAL_ENABLE_OUT, // serial traffic accepted
   output reg FRAME_START_OUT, // chip select fall pulse
   output reg FRAME_END_OUT // chip select rise pulse
);
   wire [5:0] pins_raw;
   wire [5:0] pins_q;
   // synchronised pin levels by function
   wire reset_pin_q = pins_q[0];
   wire ready_pin_q = pins_q[1];
   wire pin_a_q = pins_q[2];
   wire pin_b_q = pins_q[3];
   wire cs_pin_q = pins_q[4];
   wire sdi_pin_q = pins_q[5];

   reg por_capture_r;
   reg reset_pin_prev_r;
   reg cs_prev_r;
   reg two_wire_r;
   reg two_wire_nxt;
   reg [2:0] analog_master_clock_cnt_r;
   reg [1:0] digital_sample_clock_cnt_r;
   reg [11:0] output_rate_clock_cnt_r;
   reg [4:0] pulse_cnt_r;

   wire chip_rst;
   wire master_release;
   wire sample_mode;
   wire [1:0] prescale_eff;
   wire bitstream_en_eff;
   wire tristate_eff;
   wire ext_clock_eff;
   wire ext_ref_eff;
   wire [3:0] analog_master_clock_div;
   wire analog_master_clock_tick;
   wire digital_sample_clock_tick;
   wire [12:0] osr_len;
   wire [11:0] output_rate_clock_last;
   wire output_rate_clock_tick;
   wire [4:0] pulse_width;
   wire strap_capture;
   wire spi_live;
   wire ready_drive;

   assign pins_raw = {SERIAL_DATA_PIN_IN, CHIP_SEL_N_IN, CRYSTAL_PIN_B_IN,
      CRYSTAL_PIN_A_IN, CONV_READY_PIN_IN, MASTER_RESET_N_IN};
   // synchroniser reset levels must be constants for the instances
   localparam [5:0] pins_init = {`APMC_PIN_IDLE_LOW, `APMC_PIN_IDLE_HIGH,
      `APMC_PIN_IDLE_LOW, `APMC_PIN_IDLE_LOW, `APMC_PIN_IDLE_HIGH,
      `APMC_PIN_IDLE_LOW};

   // every shared pin passes its own synchroniser
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1)
      begin : g_sync
         apmc_pin_sync #(
            .INIT(pins_init[gi])
         ) u_sync (
            .clk_in(CLK_IN),
            .rst_in(RST_IN),
            .pin_in(pins_raw[gi]),
            .level_out(pins_q[gi])
         );
      end
   endgenerate

   // reset pin acts only in register mode and is active low
   assign chip_rst = ~two_wire_r & ~reset_pin_q;

   // settings other than the ratio code fall back to their power-on values while in reset
   assign prescale_eff = chip_rst ? `APMC_DEF_PRESCALE : PRESCALE_IN;
   assign bitstream_en_eff = chip_rst ? `APMC_DEF_BITSTREAM_EN :
      BITSTREAM_OUT_ENABLE_IN;
   assign tristate_eff = chip_rst ? `APMC_DEF_TRISTATE_CTL :
      READY_PIN_TRISTATE_CTL_IN;
   assign ext_clock_eff = (chip_rst | por_capture_r) ?
      `APMC_DEF_EXT_CLOCK_SEL : EXTERNAL_CLOCK_SELECT_IN;
   assign ext_ref_eff = chip_rst ? `APMC_DEF_EXT_REF_SEL :
      EXTERNAL_REFERENCE_SELECT_IN;

   // mode is sampled at power-on, master reset release and watchdog
   assign master_release = ~two_wire_r & ~reset_pin_prev_r & reset_pin_q;
   assign sample_mode = por_capture_r | master_release |
      WATCHDOG_RESET_IN;

   always @*
   begin
      two_wire_nxt = two_wire_r;
      if (sample_mode)
      begin
         // crystal pin b is the mode select only with a direct clock
         two_wire_nxt = ext_clock_eff & pin_b_q;
      end
   end

   // straps are taken on entry to two-wire mode and on each watchdog that keeps two-wire mode
   assign strap_capture = two_wire_nxt &
      (~two_wire_r | WATCHDOG_RESET_IN);

   // clock dividers: prescale, fixed quarter, oversampling ratio
   assign analog_master_clock_div = 4'h1 << prescale_eff;
   assign analog_master_clock_tick = analog_master_clock_cnt_r == analog_master_clock_div[2:0] - 3'h1;
   assign digital_sample_clock_tick = analog_master_clock_tick & (digital_sample_clock_cnt_r == 2'h3);
   assign osr_len = `APMC_OSR_BASE << OVERSAMPLING_RATIO_IN;
   assign output_rate_clock_last = osr_len[11:0] - 12'h001;
   assign output_rate_clock_tick = digital_sample_clock_tick & (output_rate_clock_cnt_r == output_rate_clock_last);
   // half a sample period is twice the prescale factor in cycles
   assign pulse_width = {analog_master_clock_div, 1'b0};

   assign spi_live = ~two_wire_r & ~chip_rst;
   // ready pin drives only in register mode, bitstream off
   assign ready_drive = spi_live & ~bitstream_en_eff;

   // mode, strap and pin-history state
   always @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         por_capture_r <= 1'b1;
         reset_pin_prev_r <= 1'b0;
         cs_prev_r <= 1'b1;
         two_wire_r <= 1'b0;
         OVERSAMPLE_STRAP_LO_OUT <= 1'b0;
         OVERSAMPLE_STRAP_HI_OUT <= 1'b0;
         AMP_STRAP_LO_OUT <= 1'b0;
         AMP_STRAP_HI_OUT <= 1'b0;
         BIAS_BOOST_STRAP_OUT <= 1'b0;
      end
      else
      begin
         por_capture_r <= 1'b0;
         reset_pin_prev_r <= reset_pin_q;
         cs_prev_r <= cs_pin_q;
         two_wire_r <= two_wire_nxt;
         if (strap_capture)
         begin
            // shared pins read as straps in two-wire mode
            OVERSAMPLE_STRAP_LO_OUT <= reset_pin_q;
            OVERSAMPLE_STRAP_HI_OUT <= sdi_pin_q;
            AMP_STRAP_HI_OUT <= ready_pin_q;
            AMP_STRAP_LO_OUT <= pin_a_q;
            BIAS_BOOST_STRAP_OUT <= cs_pin_q;
         end
      end
   end

   // clock divider counters, held at zero while in reset
   always @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         analog_master_clock_cnt_r <= 3'h0;
         digital_sample_clock_cnt_r <= 2'h0;
         output_rate_clock_cnt_r <= 12'h000;
      end
      else if (chip_rst)
      begin
         analog_master_clock_cnt_r <= 3'h0;
         digital_sample_clock_cnt_r <= 2'h0;
         output_rate_clock_cnt_r <= 12'h000;
      end
      else
      begin
         analog_master_clock_cnt_r <= analog_master_clock_tick ? 3'h0 : analog_master_clock_cnt_r + 3'h1;
         if (analog_master_clock_tick)
         begin
            digital_sample_clock_cnt_r <= digital_sample_clock_cnt_r + 2'h1;
         end
         if (output_rate_clock_tick)
         begin
            output_rate_clock_cnt_r <= 12'h000;
         end
         else if (digital_sample_clock_tick)
         begin
            output_rate_clock_cnt_r <= output_rate_clock_cnt_r + 12'h001;
         end
      end
   end

   // data-ready pulse: self-timed, never waits for the host
   always @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         pulse_cnt_r <= 5'h00;
      end
      else if (chip_rst)
      begin
         pulse_cnt_r <= 5'h00;
      end
      else if (output_rate_clock_tick)
      begin
         pulse_cnt_r <= pulse_width;
      end
      else if (pulse_cnt_r != 5'h00)
      begin
         pulse_cnt_r <= pulse_cnt_r - 5'h01;
      end
   end

   // pin drivers for data-ready and the modulator bitstream
   always @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         CONV_READY_N_OUT <= 1'b1;
         CONV_READY_N_OE_OUT <= 1'b0;
         MODULATOR_BITSTREAM_OUT <= 1'b0;
         MODULATOR_BITSTREAM_OE_OUT <= 1'b0;
      end
      else
      begin
         // low while a pulse runs, else idle high or floating
         CONV_READY_N_OUT <= ~(ready_drive & (output_rate_clock_tick |
            (pulse_cnt_r > 5'h01)));
         CONV_READY_N_OE_OUT <= ready_drive & (tristate_eff | output_rate_clock_tick |
            (pulse_cnt_r > 5'h01));
         // bitstream follows the modulator at the analog clock rate
         MODULATOR_BITSTREAM_OE_OUT <= spi_live & bitstream_en_eff;
         if (analog_master_clock_tick & spi_live & bitstream_en_eff)
         begin
            MODULATOR_BITSTREAM_OUT <= MOD_BIT_IN;
         end
      end
   end

   // clock, reference and bias control levels
   always @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         CHIP_RESET_OUT <= 1'b1;
         CLOCK_DIST_EN_OUT <= 1'b0;
         INPUT_CLOCK_EN_OUT <= 1'b1;
         ANALOG_BIAS_EN_OUT <= 1'b1;
         CRYSTAL_OSC_EN_OUT <= 1'b0;
         DIRECT_CLOCK_INPUT_OUT <= 1'b1;
         INT_REF_EN_OUT <= 1'b1;
         REF_PIN_SWITCH_OUT <= 1'b1;
         TWO_WIRE_MODE_OUT <= 1'b0;
         ANALOG_MASTER_CLOCK_OUT <= 1'b0;
         DIGITAL_SAMPLE_CLOCK_OUT <= 1'b0;
         OUTPUT_RATE_CLOCK_OUT <= 1'b0;
      end
      else
      begin
         CHIP_RESET_OUT <= chip_rst;
         CLOCK_DIST_EN_OUT <= ~chip_rst;
         // this clock runs, so the input structure keeps its clock
         INPUT_CLOCK_EN_OUT <= 1'b1;
         ANALOG_BIAS_EN_OUT <= 1'b1;
         CRYSTAL_OSC_EN_OUT <= ~ext_clock_eff;
         DIRECT_CLOCK_INPUT_OUT <= ext_clock_eff;
         INT_REF_EN_OUT <= ~ext_ref_eff;
         REF_PIN_SWITCH_OUT <= ~ext_ref_eff;
         TWO_WIRE_MODE_OUT <= two_wire_nxt;
         ANALOG_MASTER_CLOCK_OUT <= analog_master_clock_tick & ~chip_rst;
         DIGITAL_SAMPLE_CLOCK_OUT <= digital_sample_clock_tick & ~chip_rst;
         OUTPUT_RATE_CLOCK_OUT <= output_rate_clock_tick & ~chip_rst;
      end
   end

   // serial framing gated by chip select and reset
   always @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         SERIAL_ENABLE_OUT <= 1'b0;
         FRAME_START_OUT <= 1'b0;
         FRAME_END_OUT <= 1'b0;
      end
      else
      begin
         SERIAL_ENABLE_OUT <= spi_live & ~cs_pin_q;
         FRAME_START_OUT <= spi_live & cs_prev_r & ~cs_pin_q;
         FRAME_END_OUT <= spi_live & ~cs_prev_r & cs_pin_q;
      end
   end
endmodule // apmc_pin_mode_ctl

/* File: apmc_regs.vh */
`ifndef APMC_REGS_VH
`define APMC_REGS_VH

// master clock rate in kHz (40 MHz, 25 ns period)
`define APMC_CLK_KHZ 40000
// default values taken under power-on or master reset
`define APMC_DEF_PRESCALE 2'h0
`define APMC_DEF_BITSTREAM_EN 1'h0
`define APMC_DEF_TRISTATE_CTL 1'h0
`define APMC_DEF_EXT_CLOCK_SEL 1'h1
`define APMC_DEF_EXT_REF_SEL 1'h0
// analog clock is divided by two to this power to form the sample clock
`define APMC_SAMPLE_DIV_LOG2 2
// smallest oversampling ratio, code 0; each code step doubles it
`define APMC_OSR_BASE 13'h0020
// synchroniser reset levels of the pins
`define APMC_PIN_IDLE_HIGH 1'h1
`define APMC_PIN_IDLE_LOW 1'h0

`endif

/* File: apmc_pin_sync.v */
`timescale 1ns/1ps
module apmc_pin_sync #(
   parameter [0:0] INIT = 1'b0
) (
   input wire clk_in, // master clock
   input wire rst_in, // asynchronous reset, active high
   input wire pin_in, // raw pin level from outside
   output reg level_out // filtered, synchronised level
);
   reg stage1_r;
   reg stage2_r;
   reg stage3_r;

   // three stages; a change is taken once stages two and three agree
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         stage1_r <= INIT;
         stage2_r <= INIT;
         stage3_r <= INIT;
         level_out <= INIT;
      end
      else
      begin
         stage1_r <= pin_in;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
         if (stage2_r == stage3_r)
         begin
            level_out <= stage3_r;
         end
      end
   end
endmodule // apmc_pin_sync

/* File: apmc_pin_mode_ctl_checker.sv */
`timescale 1ns/1ps
module apmc_pin_mode_ctl_checker (
   input logic CLK_IN, // clock
   input logic RST_IN, // reset
   input logic CHIP_SEL_N_IN, // chip select pin
   input logic [1:0] PRESCALE_IN, // prescaler code
   input logic EXTERNAL_CLOCK_SELECT_IN, // clock select
   input logic EXTERNAL_REFERENCE_SELECT_IN, // reference select
   input logic CONV_READY_N_OUT, // ready level
   input logic CONV_READY_N_OE_OUT, // ready enable
   input logic MODULATOR_BITSTREAM_OE_OUT, // bitstream enable
   input logic TWO_WIRE_MODE_OUT, // mode
   input logic CHIP_RESET_OUT, // chip reset
   input logic CLOCK_DIST_EN_OUT, // clock distribution
   input logic INPUT_CLOCK_EN_OUT, // input clock
   input logic ANALOG_BIAS_EN_OUT, // biasing
   input logic CRYSTAL_OSC_EN_OUT, // oscillator
   input logic DIRECT_CLOCK_INPUT_OUT, // direct clock
   input logic INT_REF_EN_OUT, // internal reference
   input logic REF_PIN_SWITCH_OUT, // reference switch
   input logic DIGITAL_SAMPLE_CLOCK_OUT, // sample tick
   input logic SERIAL_ENABLE_OUT, // serial enable
   input logic FRAME_START_OUT, // frame start
   input logic ANALOG_MASTER_CLOCK_OUT, // analog tick
   input logic OUTPUT_RATE_CLOCK_OUT, // rate tick
   input logic FRAME_END_OUT // frame end
);
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);
   // ready low for two cycles, then high again
   sequence s_low_two;
      !CONV_READY_N_OUT ##1 !CONV_READY_N_OUT ##1 CONV_READY_N_OUT;
   endsequence
   // seven quiet cycles, then the next sample tick
   sequence s_tick_eight;
      !DIGITAL_SAMPLE_CLOCK_OUT [*7] ##1 DIGITAL_SAMPLE_CLOCK_OUT;
   endsequence
   // chip reset held two cycles
   sequence s_held_reset;
      CHIP_RESET_OUT ##1 CHIP_RESET_OUT;
   endsequence
   // held reset state of clocks, biasing and pins
   a_reset_hold_state: assert property (s_held_reset |->
      !CLOCK_DIST_EN_OUT && INPUT_CLOCK_EN_OUT && ANALOG_BIAS_EN_OUT &&
      CONV_READY_N_OUT && !CONV_READY_N_OE_OUT && !MODULATOR_BITSTREAM_OE_OUT)
      else $error("reset state wrong");
   a_no_serial_reset: assert property (s_held_reset |->
      !SERIAL_ENABLE_OUT && !FRAME_START_OUT) else $error("serial in reset");
   a_cs_high_idle: assert property (CHIP_SEL_N_IN [*6] |->
      !SERIAL_ENABLE_OUT && !FRAME_START_OUT) else $error("serial while cs high");
   a_frame_start_lag: assert property ($fell(CHIP_SEL_N_IN) &&
      !CHIP_RESET_OUT && !TWO_WIRE_MODE_OUT |-> ##[3:6] FRAME_START_OUT)
      else $error("no frame start");
   a_bits_hiz_twowire: assert property (TWO_WIRE_MODE_OUT &&
      $past(TWO_WIRE_MODE_OUT) |-> !MODULATOR_BITSTREAM_OE_OUT)
      else $error("bitstream driven in two-wire");
   a_ready_off_bits: assert property (MODULATOR_BITSTREAM_OE_OUT &&
      $past(MODULATOR_BITSTREAM_OE_OUT) |-> !CONV_READY_N_OE_OUT)
      else $error("ready driven with bitstream");
   a_ready_pulse_width: assert property (disable iff (RST_IN || CHIP_RESET_OUT)
      $fell(CONV_READY_N_OUT) && PRESCALE_IN == 2'h0 |->
      CONV_READY_N_OE_OUT ##0 s_low_two) else $error("ready pulse width");
   a_sample_period: assert property (disable iff (RST_IN || CHIP_RESET_OUT)
      DIGITAL_SAMPLE_CLOCK_OUT && PRESCALE_IN == 2'h1 |=>
      s_tick_eight) else $error("sample tick period");
   a_ref_select: assert property ((!CHIP_RESET_OUT &&
      $stable(EXTERNAL_REFERENCE_SELECT_IN)) [*3] |->
      INT_REF_EN_OUT != EXTERNAL_REFERENCE_SELECT_IN &&
      REF_PIN_SWITCH_OUT == INT_REF_EN_OUT) else $error("reference select");
   a_clock_select: assert property ((!CHIP_RESET_OUT &&
      $stable(EXTERNAL_CLOCK_SELECT_IN)) [*3] |->
      CRYSTAL_OSC_EN_OUT != EXTERNAL_CLOCK_SELECT_IN &&
      DIRECT_CLOCK_INPUT_OUT == EXTERNAL_CLOCK_SELECT_IN)
      else $error("clock select");
   // three quiet cycles, then the next analog tick
   sequence s_tick_four;
      !ANALOG_MASTER_CLOCK_OUT [*3] ##1 ANALOG_MASTER_CLOCK_OUT;
   endsequence
   a_analog_tick_div: assert property (
      disable iff (RST_IN || CHIP_RESET_OUT)
      ANALOG_MASTER_CLOCK_OUT && PRESCALE_IN == 2'h2 |=> s_tick_four)
      else $error("analog tick period");
   a_ready_on_rate: assert property (OUTPUT_RATE_CLOCK_OUT &&
      !$past(TWO_WIRE_MODE_OUT) && !MODULATOR_BITSTREAM_OE_OUT |->
      !CONV_READY_N_OUT && CONV_READY_N_OE_OUT)
      else $error("no ready pulse on rate tick");
   a_frame_end_lag: assert property ($rose(CHIP_SEL_N_IN) &&
      SERIAL_ENABLE_OUT && !CHIP_RESET_OUT && !TWO_WIRE_MODE_OUT |->
      ##[3:6] FRAME_END_OUT) else $error("no frame end");
endmodule // apmc_pin_mode_ctl_checker
bind apmc_pin_mode_ctl apmc_pin_mode_ctl_checker u_chk (.*);

/* File: apmc_host_model.sv */
`timescale 1ns/1ps
module apmc_host_model (
   input wire clk_in, // master clock
   output reg rst_n_out, // reset pin or strap
   output reg cs_n_out, // chip select or strap
   output reg mode_out, // second crystal pin
   output reg sdi_out, // data pin or strap
   output reg pin_a_out, // first crystal pin or strap
   output reg rdy_en_out, // ready pin driven as strap
   output reg rdy_out // strap level on ready pin
);
   // start in register mode with the chip held in reset
   initial
   begin
      {rst_n_out, cs_n_out, mode_out, sdi_out} = 4'h4;
      {pin_a_out, rdy_en_out, rdy_out} = 3'h0;
   end
   // master reset pin, active low
   task hold_reset(input on);
      @(posedge clk_in);
      rst_n_out <= !on;
   endtask
   // one transaction opened and closed by chip select
   task frame;
      @(posedge clk_in);
      cs_n_out <= 1'b0;
      repeat (10) @(posedge clk_in);
      cs_n_out <= 1'b1;
      repeat (10) @(posedge clk_in);
   endtask
   // strap levels and mode pin; ready pin only driven as a strap
   task drive_straps(input [4:0] s, input two_wire);
      @(posedge clk_in);
      {rst_n_out, sdi_out, rdy_out, pin_a_out, cs_n_out} <= s;
      {mode_out, rdy_en_out} <= {2{two_wire}};
   endtask
endmodule // apmc_host_model

/* File: apmc_pin_mode_ctl_tb.sv */
`timescale 1ns/1ps
module apmc_pin_mode_ctl_tb;
   // {prescale, ratio code, bitstream enable}, all prescale codes used
   localparam [35:0] CFG = {6'h00, 6'h08, 6'h12, 6'h20, 6'h01, 6'h31};
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg wdg = 1'b0;
   reg mod = 1'b0;
   reg [1:0] pre = 2'h0;
   reg [2:0] oversampling_ratio = 3'h0;
   reg ben = 1'b0, tsc = 1'b0, eck = 1'b1, erf = 1'b0;
   reg [15:0] rnd = 16'h4DFF;
   reg [4:0] s, s2;
   integer fails = 0, num_checks = 0, cyc = 0, fcnt = 0;
   integer i, j, n, w, f0;
   wire rdy, rdy_oe, bs, bs_oe, tw, crst, iref, xosc, fst;
   wire [4:0] strap;
   wire rst_n_p, cs_n_p, mode_p, sdi_p, pa_p, ren, rv;
   // released ready pin sits on its pull-up
   wire rdy_pin = rdy_oe ? rdy : (ren ? rv : 1'b1);
   apmc_host_model host (.clk_in(clk), .rst_n_out(rst_n_p),
      .cs_n_out(cs_n_p), .mode_out(mode_p), .sdi_out(sdi_p),
      .pin_a_out(pa_p), .rdy_en_out(ren), .rdy_out(rv));
   apmc_pin_mode_ctl DUT (.CLK_IN(clk), .RST_IN(rst),
      .MASTER_RESET_N_IN(rst_n_p), .CONV_READY_PIN_IN(rdy_pin),
      .CRYSTAL_PIN_A_IN(pa_p), .CRYSTAL_PIN_B_IN(mode_p),
      .CHIP_SEL_N_IN(cs_n_p), .SERIAL_DATA_PIN_IN(sdi_p),
      .WATCHDOG_RESET_IN(wdg), .MOD_BIT_IN(mod), .PRESCALE_IN(pre),
      .OVERSAMPLING_RATIO_IN(oversampling_ratio), .BITSTREAM_OUT_ENABLE_IN(ben),
      .READY_PIN_TRISTATE_CTL_IN(tsc), .EXTERNAL_CLOCK_SELECT_IN(eck),
      .EXTERNAL_REFERENCE_SELECT_IN(erf), .CONV_READY_N_OUT(rdy),
      .CONV_READY_N_OE_OUT(rdy_oe), .MODULATOR_BITSTREAM_OUT(bs),
      .MODULATOR_BITSTREAM_OE_OUT(bs_oe), .TWO_WIRE_MODE_OUT(tw),
      .OVERSAMPLE_STRAP_LO_OUT(strap[4]), .OVERSAMPLE_STRAP_HI_OUT(strap[3]),
      .AMP_STRAP_HI_OUT(strap[2]), .AMP_STRAP_LO_OUT(strap[1]),
      .BIAS_BOOST_STRAP_OUT(strap[0]), .CHIP_RESET_OUT(crst),
      .CLOCK_DIST_EN_OUT(), .INPUT_CLOCK_EN_OUT(), .ANALOG_BIAS_EN_OUT(),
      .CRYSTAL_OSC_EN_OUT(xosc), .DIRECT_CLOCK_INPUT_OUT(),
      .INT_REF_EN_OUT(iref), .REF_PIN_SWITCH_OUT(),
      .ANALOG_MASTER_CLOCK_OUT(), .DIGITAL_SAMPLE_CLOCK_OUT(),
      .OUTPUT_RATE_CLOCK_OUT(), .SERIAL_ENABLE_OUT(), .FRAME_START_OUT(fst),
      .FRAME_END_OUT());
   // 40 MHz clock
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   // frame start counter and run-length guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (fst === 1'b1)
         fcnt <= fcnt + 1;
      if (cyc == 30000)
      begin
         fails = fails + 1;
         test_done;
      end
   end
   function [15:0] lfsr(input [15:0] v);
      lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // expected ready period, or pulse width when per is 0
   function [31:0] exp_ready(input [1:0] p, input [2:0] o, input per);
      exp_ready = per ? 32'h80 << ({2'h0, p} + o) : 32'h2 << p;
   endfunction
   task chk(input [31:0] exp, input [31:0] got, input [95:0] nm);
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("ERROR %0s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task tick(input integer c);
      repeat (c) @(negedge clk);
   endtask
   task wait_lvl(input v);
      for (n = 0; n < 3000 && rdy !== v; n = n + 1)
         @(negedge clk);
   endtask
   task pulse_wdg;
      @(posedge clk);
      wdg <= 1'b1;
      @(posedge clk);
      wdg <= 1'b0;
      tick(6);
   endtask
   // settings changed only while the chip is held in reset
   task run_cfg(input [1:0] p, input [2:0] o, input b);
      host.hold_reset(1'b1);
      tick(8);
      f0 = fcnt;
      host.frame;
      chk(f0, fcnt, "frame in rst");
      rnd = lfsr(rnd);
      @(posedge clk);
      {pre, oversampling_ratio, ben} <= {p, o, b};
      {tsc, erf, eck} <= rnd[2:0];
      host.hold_reset(1'b0);
      for (n = 0; n < 50 && crst !== 1'b0; n = n + 1)
         @(negedge clk);
      tick(3);
      chk(0, crst, "chip reset");
      chk(!erf, iref, "int ref");
      chk(!eck, xosc, "crystal osc");
      f0 = fcnt;
      host.frame;
      chk(f0 + 1, fcnt, "frame count");
      for (j = 0; j < 2 && b; j = j + 1)
      begin
         @(posedge clk);
         mod <= !j[0];
         tick(9);
         chk(!j[0], bs, "bitstream");
         chk(0, rdy_oe, "ready oe");
      end
      if (!b)
      begin
         chk(0, bs_oe, "bitstream oe");
         wait_lvl(0);
         wait_lvl(1);
         wait_lvl(0);
         chk(1, rdy_oe, "pulse oe");
         wait_lvl(1);
         w = n;
         chk(tsc, rdy_oe, "ready idle");
         wait_lvl(0);
         chk(exp_ready(p, o, 1'b0), w, "pulse width");
         chk(exp_ready(p, o, 1'b1), w + n, "period");
      end
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      tick(2);
      chk(1, crst, "chip reset");
      chk(0, tw, "mode");
      chk(1, iref, "int ref");
      for (i = 5; i >= 0; i = i - 1)
         run_cfg(CFG[i*6+5 -: 2], CFG[i*6+3 -: 3], CFG[i*6]);
      // mode pin only counts with the direct clock selected
      @(posedge clk);
      eck <= 1'b1;
      rnd = lfsr(rnd);
      s = {1'b1, rnd[3:0]};
      host.drive_straps(s, 1'b1);
      tick(10);
      pulse_wdg;
      chk(1, tw, "two wire");
      chk(s, strap, "strap entry");
      chk(0, bs_oe, "bits in tw");
      rnd = lfsr(rnd);
      s2 = rnd[4:0];
      host.drive_straps(s2, 1'b1);
      tick(10);
      chk(s, strap, "strap hold");
      pulse_wdg;
      chk(s2, strap, "strap recap");
      host.drive_straps(5'h11, 1'b0);
      tick(10);
      chk(1, tw, "mode hold");
      pulse_wdg;
      chk(0, tw, "mode exit");
      test_done;
   end
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
endmodule // apmc_pin_mode_ctl_tb
